// File: pkg/dcf_pkg.sv
// constants, pin carriers and state types for the 9-bit flagged fifo
// assumes a single system clock; fifo clocks arrive as sampled pins
package dcf_pkg;

  // ==========================================================
  // sizes
  localparam int DEPTH       = 64;
  localparam int WIDTH       = 9;
  localparam int AW          = 6;
  localparam int CW          = 7;
  localparam int STAGE_DEPTH = 4;
  localparam int STAGE_CW    = 3;

  // ==========================================================
  // timing: skew limits in ns and in system clock cycles
  localparam int CLK_NS      = 5;
  localparam int SKEW_A_NS   = 5;
  localparam int SKEW_B_NS   = 10;
  localparam int SKEW_A_CYC  = (SKEW_A_NS + CLK_NS - 1) / CLK_NS;
  localparam int SKEW_B_CYC  = (SKEW_B_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_STAGES = 2;

  // ==========================================================
  // reset values
  localparam logic [AW-1:0]    OFS_DEFAULT = 6'h07;
  localparam logic [CW-1:0]    CNT_FULL    = 7'h40;
  localparam logic [CW-1:0]    CNT_ZERO    = 7'h00;
  localparam logic [WIDTH-1:0] DOUT_RESET  = 9'h000;

  // ==========================================================
  // register port map
  localparam int             REG_AW       = 4;
  localparam logic [REG_AW-1:0] REG_EMPTY_OFS = 4'h0;
  localparam logic [REG_AW-1:0] REG_FULL_OFS  = 4'h4;
  localparam logic [REG_AW-1:0] REG_STATUS    = 4'h8;
  localparam int ST_FULL    = 0;
  localparam int ST_EMPTY   = 1;
  localparam int ST_AEMPTY  = 2;
  localparam int ST_AFULL   = 3;
  localparam int ST_MODE    = 4;
  localparam int ST_CNT_LSB = 8;

  // ==========================================================
  // types
  typedef enum logic { DCF_MODE_SECOND_EN, DCF_MODE_LOAD } dcf_mode_t;
  typedef enum logic { DCF_LD_EMPTY_OFS, DCF_LD_FULL_OFS } dcf_ld_sel_t;
  typedef enum logic [1:0] { DCF_SEL_NONE, DCF_SEL_EOFS, DCF_SEL_FOFS, DCF_SEL_STAT } dcf_reg_sel_t;

  typedef struct packed {
    logic [WIDTH-1:0] data;
    logic             wr_en_primary_n;
    logic             wr_en2_or_load;
  } dcf_wr_pins_t;

  typedef struct packed {
    logic rd_en_primary_n;
    logic rd_en_second_n;
    logic oe_n;
  } dcf_rd_pins_t;

  typedef struct packed {
    logic full_n;
    logic empty_n;
    logic almost_empty_n;
    logic almost_full_n;
  } dcf_flags_t;

  localparam dcf_flags_t FLAGS_RESET = '{full_n: 1'b1, empty_n: 1'b0, almost_empty_n: 1'b0, almost_full_n: 1'b1};

endpackage : dcf_pkg

// File: src/dcf_stage_fifo.sv
// small staging fifo with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/100ps
module dcf_stage_fifo #(
  parameter int W  = 9,
  parameter int D  = 4,
  parameter int PW = 2
) (
  input  wire logic         sys_clk_in,  // system clock
  input  wire logic         rst_in,      // sync reset
  input  wire logic         in_valid_in, // word offered
  output logic              in_ready_out,// room for a word
  input  wire logic [W-1:0] in_data_in,  // offered word
  output logic              out_valid_out,// word available
  input  wire logic         out_ready_in,// drain side accepts
  output logic [W-1:0]      out_data_out // oldest word
);

  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0]   cnt;
  } dcf_stage_st_t;

  dcf_stage_st_t st_q;
  dcf_stage_st_t st_d;
  logic [W-1:0]  mem_q [D];
  logic          push;
  logic          pop;

  // ==========================================================
  // handshakes
  assign in_ready_out  = (st_q.cnt != (PW+1)'(D));
  assign out_valid_out = (st_q.cnt != '0);
  assign out_data_out  = mem_q[st_q.rp];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.wp = st_q.wp + 1'b1;
    end
    if (pop) begin
      st_d.rp = st_q.rp + 1'b1;
    end
    st_d.cnt = st_q.cnt + (PW+1)'(push) - (PW+1)'(pop);
    if (rst_in) begin
      st_d = '0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    st_q <= st_d;
    if (push) begin
      mem_q[st_q.wp] <= in_data_in;
    end
  end

endmodule : dcf_stage_fifo

// File: src/dcf_fifo_top.sv
// flagged 64 x 9 fifo with pin-clocked write and read ports
// assumes write/read clocks and all pins are asynchronous to sys_clk_in
//
// What this block does
// - full flag release may slip one write edge
// - empty flag release may slip one read edge
// - almost-empty change may slip one read edge
// - almost-full change may slip one write edge
// - reset works with both fifo clocks running
// - dual pin high at reset: second write enable
// - dual pin low at reset: offset load control
// - data outputs low after reset, enabled by oe
// - first word appears cycle after empty releases
// - first-read latency bounded by one or two periods
// - almost-empty asserts at empty offset level
// - almost-full asserts at depth minus offset
// - almost-full threshold is depth minus offset
// - full flag blocks writes, updates on write edges
// - empty flag blocks reads, updates on read edges
// - empty offset resets to seven
// - full offset resets to seven
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/100ps
module dcf_fifo_top (
  input  wire logic                    sys_clk_in,     // system clock, 200 MHz
  input  wire logic                    rst_in,         // sync reset, active high
  input  wire logic                    wr_clk_in,      // write clock pin
  input  wire dcf_pkg::dcf_wr_pins_t   wr_pins_in,     // write data and enables
  input  wire logic                    rd_clk_in,      // read clock pin
  input  wire dcf_pkg::dcf_rd_pins_t   rd_pins_in,     // read enables and oe
  output logic [dcf_pkg::WIDTH-1:0]    data_out,       // read data
  output logic                         data_oe_out,    // read data drive enable
  output dcf_pkg::dcf_flags_t          flags_out,      // status flags, active low
  input  wire logic [dcf_pkg::REG_AW-1:0] reg_addr_in, // register address
  input  wire logic [31:0]             reg_wdata_in,   // register write data
  input  wire logic                    reg_wr_in,      // register write strobe
  input  wire logic                    reg_rd_in,      // register read strobe
  output logic [31:0]                  reg_rdata_out   // register read data
);
  import dcf_pkg::*;

  typedef struct packed {
    logic [2:0]       wclk_s;
    logic [2:0]       rclk_s;
    dcf_wr_pins_t     wpin_s0;
    dcf_wr_pins_t     wpin_s1;
    dcf_wr_pins_t     wpin_s2;
    dcf_rd_pins_t     rpin_s0;
    dcf_rd_pins_t     rpin_s1;
    dcf_rd_pins_t     rpin_s2;
    dcf_mode_t        mode;
    dcf_ld_sel_t      ld_sel;
    logic [AW-1:0]    ofs_e;
    logic [AW-1:0]    ofs_f;
    logic [CW-1:0]    tot;
    logic [CW-1:0]    mcnt;
    logic [AW-1:0]    wptr;
    logic [AW-1:0]    rptr;
    dcf_flags_t       flags;
    logic [WIDTH-1:0] dout;
    logic [31:0]      rdata;
  } dcf_state_t;

  dcf_state_t       st_q;
  dcf_state_t       st_d;
  logic [WIDTH-1:0] mem_q [DEPTH];

  logic             wrise;
  logic             rrise;
  logic             wr_req;
  logic             ld_req;
  logic             wr_take;
  logic             rd_req;
  logic             rd_take;
  logic             stg_in_ready;
  logic             stg_out_valid;
  logic             drain;
  logic [WIDTH-1:0] stg_out_data;
  logic [31:0]      status_word;

  // ==========================================================
  // register address decode
  function automatic dcf_reg_sel_t reg_decode(input logic [REG_AW-1:0] a);
    if (a == REG_EMPTY_OFS) begin
      return DCF_SEL_EOFS;
    end else if (a == REG_FULL_OFS) begin
      return DCF_SEL_FOFS;
    end else if (a == REG_STATUS) begin
      return DCF_SEL_STAT;
    end else begin
      return DCF_SEL_NONE;
    end
  endfunction : reg_decode

  // ==========================================================
  // edge detection on synchronised fifo clocks
  // data and enables are taken from the sample just before the edge
  assign wrise = st_q.wclk_s[1] && !st_q.wclk_s[2];
  assign rrise = st_q.rclk_s[1] && !st_q.rclk_s[2];

  // dual pin must be high for a fifo write in either mode
  assign wr_req  = wrise && !st_q.wpin_s2.wr_en_primary_n && st_q.wpin_s2.wr_en2_or_load;
  assign ld_req  = wrise && !st_q.wpin_s2.wr_en_primary_n && !st_q.wpin_s2.wr_en2_or_load
                   && (st_q.mode == DCF_MODE_LOAD);
  assign wr_take = wr_req && st_q.flags.full_n && stg_in_ready;
  assign rd_req  = rrise && !st_q.rpin_s2.rd_en_primary_n && !st_q.rpin_s2.rd_en_second_n;
  assign rd_take = rd_req && st_q.flags.empty_n && (st_q.mcnt != CNT_ZERO);

  // staged words move into the main array whenever it has room
  assign drain = stg_out_valid && (st_q.mcnt != CNT_FULL);

  dcf_stage_fifo #(
    .W  (WIDTH),
    .D  (STAGE_DEPTH),
    .PW (STAGE_CW - 1)
  ) u_stage (
    .sys_clk_in    (sys_clk_in),
    .rst_in        (rst_in),
    .in_valid_in   (wr_take),
    .in_ready_out  (stg_in_ready),
    .in_data_in    (st_q.wpin_s2.data),
    .out_valid_out (stg_out_valid),
    .out_ready_in  (st_q.mcnt != CNT_FULL),
    .out_data_out  (stg_out_data)
  );

  // ==========================================================
  // status word
  always_comb begin
    status_word                          = '0;
    status_word[ST_FULL]                 = st_q.flags.full_n;
    status_word[ST_EMPTY]                = st_q.flags.empty_n;
    status_word[ST_AEMPTY]               = st_q.flags.almost_empty_n;
    status_word[ST_AFULL]                = st_q.flags.almost_full_n;
    status_word[ST_MODE]                 = (st_q.mode == DCF_MODE_LOAD);
    status_word[ST_CNT_LSB +: CW]        = st_q.tot;
  end

  // ==========================================================
  // next state
  always_comb begin
    st_d = st_q;
    // pin synchronisers run through reset so free-running clocks are safe
    st_d.wclk_s  = {st_q.wclk_s[1:0], wr_clk_in};
    st_d.rclk_s  = {st_q.rclk_s[1:0], rd_clk_in};
    st_d.wpin_s0 = wr_pins_in;
    st_d.wpin_s1 = st_q.wpin_s0;
    st_d.wpin_s2 = st_q.wpin_s1;
    st_d.rpin_s0 = rd_pins_in;
    st_d.rpin_s1 = st_q.rpin_s0;
    st_d.rpin_s2 = st_q.rpin_s1;

    st_d.tot  = st_q.tot + CW'(wr_take) - CW'(rd_take);
    st_d.mcnt = st_q.mcnt + CW'(drain) - CW'(rd_take);
    if (drain) begin
      st_d.wptr = st_q.wptr + 1'b1;
    end
    if (rd_take) begin
      st_d.rptr = st_q.rptr + 1'b1;
      st_d.dout = mem_q[st_q.rptr];
    end

    // write-side flags change only on write clock edges
    if (wrise) begin
      st_d.flags.full_n        = (st_d.tot != CNT_FULL);
      st_d.flags.almost_full_n = (st_d.tot < (CNT_FULL - CW'(st_q.ofs_f)));
    end
    // read-side flags change only on read clock edges
    if (rrise) begin
      st_d.flags.empty_n        = (st_d.mcnt != CNT_ZERO);
      st_d.flags.almost_empty_n = (st_d.mcnt > CW'(st_q.ofs_e));
    end

    // offset load through the dual pin alternates empty then full offset
    if (ld_req) begin
      if (st_q.ld_sel == DCF_LD_EMPTY_OFS) begin
        st_d.ofs_e  = st_q.wpin_s2.data[AW-1:0];
        st_d.ld_sel = DCF_LD_FULL_OFS;
      end else begin
        st_d.ofs_f  = st_q.wpin_s2.data[AW-1:0];
        st_d.ld_sel = DCF_LD_EMPTY_OFS;
      end
    end

    if (reg_wr_in) begin
      case (reg_decode(reg_addr_in))
        DCF_SEL_EOFS: begin
          st_d.ofs_e = reg_wdata_in[AW-1:0];
        end
        DCF_SEL_FOFS: begin
          st_d.ofs_f = reg_wdata_in[AW-1:0];
        end
        default: begin
        end
      endcase
    end

    st_d.rdata = '0;
    if (reg_rd_in) begin
      case (reg_decode(reg_addr_in))
        DCF_SEL_EOFS: begin
          st_d.rdata[AW-1:0] = st_q.ofs_e;
        end
        DCF_SEL_FOFS: begin
          st_d.rdata[AW-1:0] = st_q.ofs_f;
        end
        DCF_SEL_STAT: begin
          st_d.rdata = status_word;
        end
        default: begin
        end
      endcase
    end

    if (rst_in) begin
      st_d.mode   = st_q.wpin_s1.wr_en2_or_load ? DCF_MODE_SECOND_EN : DCF_MODE_LOAD;
      st_d.ld_sel = DCF_LD_EMPTY_OFS;
      st_d.ofs_e  = OFS_DEFAULT;
      st_d.ofs_f  = OFS_DEFAULT;
      st_d.tot    = CNT_ZERO;
      st_d.mcnt   = CNT_ZERO;
      st_d.wptr   = '0;
      st_d.rptr   = '0;
      st_d.flags  = FLAGS_RESET;
      st_d.dout   = DOUT_RESET;
      st_d.rdata  = '0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    st_q <= st_d;
  end

  always_ff @(posedge sys_clk_in) begin
    if (drain) begin
      mem_q[st_q.wptr] <= stg_out_data;
    end
  end

  // ==========================================================
  // outputs
  assign data_out      = st_q.dout;
  assign data_oe_out   = !st_q.rpin_s1.oe_n;
  assign flags_out     = st_q.flags;
  assign reg_rdata_out = st_q.rdata;

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);

  a_full_blocks_write: assert property (wr_req && !st_q.flags.full_n && !rd_take |=> st_q.tot == $past(st_q.tot))
    else $error("write accepted while full");

  a_empty_blocks_rd: assert property (rd_req && !st_q.flags.empty_n |=> $stable(st_q.dout) && $stable(st_q.rptr))
    else $error("read accepted while empty");

  a_wflags_on_wedge: assert property (!wrise |=> $stable(st_q.flags.full_n) && $stable(st_q.flags.almost_full_n))
    else $error("write flags moved without write edge");

  a_rflags_on_redge: assert property (!rrise |=> $stable(st_q.flags.empty_n) && $stable(st_q.flags.almost_empty_n))
    else $error("read flags moved without read edge");

  a_full_value: assert property (wrise |=> st_q.flags.full_n == (st_q.tot != CNT_FULL))
    else $error("full flag disagrees with count");

  a_afull_thresh: assert property (wrise |=> st_q.flags.almost_full_n
                                   == (st_q.tot < CNT_FULL - CW'($past(st_q.ofs_f))))
    else $error("almost full threshold wrong");

  a_aempty_thresh: assert property (rrise |=> st_q.flags.almost_empty_n
                                    == (st_q.mcnt > CW'($past(st_q.ofs_e))))
    else $error("almost empty threshold wrong");

  a_first_word: assert property ($changed(st_q.dout) |-> $past(rrise) && $past(st_q.flags.empty_n))
    else $error("data changed without a qualified read");

  a_second_enable: assert property ((st_q.mode == DCF_MODE_SECOND_EN) && wrise && !st_q.wpin_s2.wr_en2_or_load
                                    && !rd_take |=> st_q.tot == $past(st_q.tot))
    else $error("write taken with second enable inactive");

  a_load_offset: assert property (ld_req && (st_q.ld_sel == DCF_LD_EMPTY_OFS) && !reg_wr_in
                                  |=> st_q.ofs_e == $past(st_q.wpin_s2.data[AW-1:0]))
    else $error("offset load through pin lost");

  a_reset_state: assert property (disable iff (1'b0) rst_in |=> st_q.dout == DOUT_RESET
                                  && st_q.flags == FLAGS_RESET && st_q.ofs_e == OFS_DEFAULT
                                  && st_q.ofs_f == OFS_DEFAULT)
    else $error("reset state wrong");

endmodule : dcf_fifo_top

// File: verif/dcf_pin_partner.sv
// producer and consumer on the fifo pins: write and read clocks, enables, data, oe
// assumes the bench calls one task at a time, each entered just after a sys_clk_in edge
`timescale 1ns/100ps
module dcf_pin_partner (
  input  wire logic              sys_clk_in,  // system clock
  output logic                   wr_clk_out,  // write clock pin
  output dcf_pkg::dcf_wr_pins_t  wr_pins_out, // write data and enables
  output logic                   rd_clk_out,  // read clock pin
  output dcf_pkg::dcf_rd_pins_t  rd_pins_out  // read enables and oe
);
  import dcf_pkg::*;
  logic strap_q;

  initial begin
    strap_q     = 1'b1;
    wr_clk_out  = 1'b0;
    rd_clk_out  = 1'b0;
    wr_pins_out = '{data: 9'h155, wr_en_primary_n: 1'b1, wr_en2_or_load: 1'b1};
    rd_pins_out = '{rd_en_primary_n: 1'b1, rd_en_second_n: 1'b1, oe_n: 1'b0};
  end

  // ==========================================================
  // dual pin level held across reset picks its role
  task automatic set_strap(input logic lvl);
    strap_q = lvl;
    wr_pins_out.wr_en2_or_load <= lvl;
  endtask : set_strap

  task automatic set_oe(input logic oe_n);
    rd_pins_out.oe_n <= oe_n;
  endtask : set_oe

  // both clocks keep running, enables idle
  task automatic spin(input int n);
    repeat (2 * n) begin
      repeat (2) @(posedge sys_clk_in);
      wr_clk_out <= ~wr_clk_out;
      rd_clk_out <= ~rd_clk_out;
    end
  endtask : spin

  // ==========================================================
  // one write clock edge; phases of three system cycles
  task automatic wr_word(input logic [WIDTH-1:0] d, input logic en1_n, input logic en2);
    @(posedge sys_clk_in);
    wr_pins_out <= '{data: d, wr_en_primary_n: en1_n, wr_en2_or_load: en2};
    repeat (2) @(posedge sys_clk_in);
    wr_clk_out <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    wr_clk_out <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    // released data shows the inverse so a stale word cannot pass
    wr_pins_out <= '{data: ~d, wr_en_primary_n: 1'b1, wr_en2_or_load: strap_q};
  endtask : wr_word

  task automatic rd_word(input logic en_n);
    @(posedge sys_clk_in);
    rd_pins_out.rd_en_primary_n <= en_n;
    rd_pins_out.rd_en_second_n  <= en_n;
    repeat (2) @(posedge sys_clk_in);
    rd_clk_out <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    rd_clk_out <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    rd_pins_out.rd_en_primary_n <= 1'b1;
    rd_pins_out.rd_en_second_n  <= 1'b1;
  endtask : rd_word

endmodule : dcf_pin_partner

// File: verif/dcf_fifo_top_tb.sv
// self-checking bench for the flagged fifo: pins via the partner, registers via the bench
// assumes 200 MHz system clock and the register map of the package
`timescale 1ns/100ps
module dcf_fifo_top_tb;
  import dcf_pkg::*;
  logic                  sys_clk_in;
  logic                  rst_in;
  logic [REG_AW-1:0]     reg_addr_in;
  logic [31:0]           reg_wdata_in;
  logic                  reg_wr_in;
  logic                  reg_rd_in;
  logic [31:0]           reg_rdata_out;
  logic                  wr_clk_in;
  logic                  rd_clk_in;
  dcf_wr_pins_t          wr_pins_in;
  dcf_rd_pins_t          rd_pins_in;
  logic [WIDTH-1:0]      data_out;
  logic                  data_oe_out;
  dcf_flags_t            flags_out;
  int                    err_total = 0;
  int                    num_checks = 0;
  logic [31:0]           rd_q;

  always #2.5 sys_clk_in = ~sys_clk_in;

  dcf_fifo_top u_dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .wr_clk_in(wr_clk_in), .wr_pins_in(wr_pins_in),
    .rd_clk_in(rd_clk_in), .rd_pins_in(rd_pins_in), .data_out(data_out), .data_oe_out(data_oe_out),
    .flags_out(flags_out), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out));

  dcf_pin_partner u_far (.sys_clk_in(sys_clk_in), .wr_clk_out(wr_clk_in), .wr_pins_out(wr_pins_in),
    .rd_clk_out(rd_clk_in), .rd_pins_out(rd_pins_in));

  // ==========================================================
  // helpers
  task automatic end_sim();
    if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic reg_wr(input logic [REG_AW-1:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_in    <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [REG_AW-1:0] a);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd_in   <= 1'b0;
    #1 rd_q = reg_rdata_out;
  endtask : reg_rd

  function automatic logic [WIDTH-1:0] word_of(input int i);
    return WIDTH'(i * 7 + 3);
  endfunction : word_of

  task automatic t_reset(input logic lvl);
    @(posedge sys_clk_in);
    u_far.set_strap(lvl);
    repeat (3) @(posedge sys_clk_in);
    rst_in <= 1'b1;
    fork
      u_far.spin(2);
      repeat (6) @(posedge sys_clk_in);
    join
    rst_in <= 1'b0;
  endtask : t_reset

  // ==========================================================
  // scenarios
  task automatic sc_after_reset();
    chk(32'(flags_out), 32'(FLAGS_RESET));
    chk(32'(data_out), 32'(DOUT_RESET));
    chk(32'(data_oe_out), 32'h0000_0001);
    @(posedge sys_clk_in);
    u_far.set_oe(1'b1);
    repeat (4) @(posedge sys_clk_in);
    chk(32'(data_oe_out), 32'h0000_0000);
    u_far.set_oe(1'b0);
    reg_rd(REG_EMPTY_OFS);
    chk(rd_q, 32'(OFS_DEFAULT));
    reg_rd(REG_FULL_OFS);
    chk(rd_q, 32'(OFS_DEFAULT));
    reg_rd(REG_STATUS);
    chk(rd_q & 32'h0000_7F10, 32'h0000_0000);
  endtask : sc_after_reset

  task automatic sc_first_word();
    u_far.wr_word(9'h0AA, 1'b0, 1'b0);
    reg_rd(REG_STATUS);
    chk(32'(rd_q[14:8]), 32'h0000_0000);
    u_far.wr_word(9'h1A5, 1'b0, 1'b1);
    chk(32'(flags_out.empty_n), 32'h0000_0000);
    u_far.rd_word(1'b0);
    chk(32'(flags_out.empty_n), 32'h0000_0001);
    chk(32'(data_out), 32'h0000_0000);
    u_far.rd_word(1'b0);
    chk(32'(data_out), 32'h0000_01A5);
    chk(32'(flags_out.empty_n), 32'h0000_0000);
    u_far.rd_word(1'b0);
    chk(32'(data_out), 32'h0000_01A5);
  endtask : sc_first_word

  task automatic sc_fill_drain();
    int cnt;
    for (int i = 0; i < DEPTH + 1; i++) begin
      u_far.wr_word(word_of(i), 1'b0, 1'b1);
      cnt = (i + 1 > DEPTH) ? DEPTH : i + 1;
      reg_rd(REG_STATUS);
      chk(32'(rd_q[14:8]), 32'(cnt));
      chk(32'(flags_out.full_n), 32'(cnt < DEPTH));
      chk(32'(flags_out.almost_full_n), 32'(cnt < DEPTH - 7));
    end
    u_far.rd_word(1'b0);
    u_far.rd_word(1'b0);
    chk(32'(data_out), 32'(word_of(0)));
    chk(32'(flags_out.full_n), 32'h0000_0000);
    u_far.wr_word(9'h000, 1'b1, 1'b1);
    chk(32'(flags_out.full_n), 32'h0000_0001);
    for (int i = 1; i < DEPTH; i++) begin
      u_far.rd_word(1'b0);
      cnt = DEPTH - 1 - i;
      chk(32'(data_out), 32'(word_of(i)));
      chk(32'(flags_out.empty_n), 32'(cnt > 0));
      chk(32'(flags_out.almost_empty_n), 32'(cnt > 7));
    end
  endtask : sc_fill_drain

  task automatic sc_regs();
    reg_wr(REG_EMPTY_OFS, 32'h0000_0003);
    reg_wr(REG_FULL_OFS, 32'hFFFF_FFC2);
    reg_wr(4'hC, 32'h0000_0011);
    reg_wr(REG_STATUS, 32'hFFFF_FFFF);
    reg_rd(REG_EMPTY_OFS);
    chk(rd_q, 32'h0000_0003);
    reg_rd(REG_FULL_OFS);
    chk(rd_q, 32'h0000_0002);
    reg_rd(4'hC);
    chk(rd_q, 32'h0000_0000);
    reg_rd(REG_STATUS);
    chk(rd_q & 32'hFFFF_FF17, 32'h0000_0001);
  endtask : sc_regs

  task automatic sc_load_mode();
    t_reset(1'b0);
    reg_rd(REG_STATUS);
    chk(rd_q & 32'h0000_7F10, 32'h0000_0010);
    u_far.wr_word(9'h005, 1'b0, 1'b0);
    u_far.wr_word(9'h009, 1'b0, 1'b0);
    reg_rd(REG_EMPTY_OFS);
    chk(rd_q, 32'h0000_0005);
    reg_rd(REG_FULL_OFS);
    chk(rd_q, 32'h0000_0009);
    u_far.wr_word(9'h123, 1'b0, 1'b1);
    reg_rd(REG_STATUS);
    chk(32'(rd_q[14:8]), 32'h0000_0001);
  endtask : sc_load_mode

  // ==========================================================
  // main sequence and watchdog
  initial begin
    sys_clk_in   = 1'b0;
    rst_in       = 1'b1;
    reg_addr_in  = '0;
    reg_wdata_in = '0;
    reg_wr_in    = 1'b0;
    reg_rd_in    = 1'b0;
    // reset spans four system cycles while both fifo clocks toggle
    fork
      u_far.spin(1);
      repeat (4) @(posedge sys_clk_in);
    join
    rst_in <= 1'b0;
    @(posedge sys_clk_in);
    #1;
    sc_after_reset();
    sc_first_word();
    sc_fill_drain();
    sc_regs();
    sc_load_mode();
    end_sim();
  end

  initial begin
    repeat (100000) @(posedge sys_clk_in);
    err_total++;
    end_sim();
  end

endmodule : dcf_fifo_top_tb
